// File: bench/rg_nbr_model.sv
// neighbouring ring node model driving one fibre input of the node
`timescale 1ns/1ns
module rg_nbr_model
    import rg_pkg::*;
(
    input  wire logic    sys_clk_i,
    input  wire rg_fib_t sym_i,
    input  wire logic    up_i,
    output rg_fib_t      fibre_o,
    output logic         link_up_o
);
    // --------------------------------------------------
    // fibre link
    // --------------------------------------------------
    // a dark fibre flips between the last symbol and its inverse each cycle, so the node
    // must really ignore a down port; while up, the symbol sent is only what the
    // bench commands, and rts is raised by it alone
    initial begin
        fibre_o   = 4'h3;
        link_up_o = 1'b0;
        forever begin
            @(posedge sys_clk_i);
            fibre_o   <= up_i ? sym_i : ~fibre_o;
            link_up_o <= up_i;
        end
    end
endmodule

// File: bench/rg_ring_repeater_test.sv
// self-checking bench for the dual channel ring repeater
`timescale 1ns/1ns
`include "rg_cfg.svh"
module rg_ring_repeater_test
    import rg_pkg::*;
;
    typedef struct packed {
        logic       chan;
        logic       focal;
        logic [1:0] fa;
        logic [1:0] fb;
        logic [1:0] ea;
        logic [1:0] eb;
        logic       tx;
    } rg_row_t;
    logic    sys_clk, rst, ce, up_a, up_b, rxd, rts, pwr;
    logic    la, lb, txd, cts, lamp_l, lamp_r, lamp_a, lamp_b, alarm;
    rg_fib_t sym_a, sym_b, fa, fb, out_a, out_b;
    rg_sw_t  sw;
    rg_row_t rows [8];
    int      bad_count = 0;
    int      cmp_count = 0;
    rg_nbr_model i_rg_nbr_model_a (.sys_clk_i(sys_clk), .sym_i(sym_a), .up_i(up_a),
                                   .fibre_o(fa), .link_up_o(la));
    rg_nbr_model i_rg_nbr_model_b (.sys_clk_i(sys_clk), .sym_i(sym_b), .up_i(up_b),
                                   .fibre_o(fb), .link_up_o(lb));
    rg_ring_repeater i_rg_ring_repeater (
        .sys_clk_i(sys_clk), .rst_i(rst), .ce_i(ce), .fibre_in_a_i(fa),
        .fibre_in_b_i(fb), .link_up_a_i(la), .link_up_b_i(lb), .ser_rxd_i(rxd),
        .ser_rts_i(rts), .pwr_fail_i(pwr), .switches_i(sw), .fibre_out_a_o(out_a),
        .fibre_out_b_o(out_b), .ser_txd_o(txd), .ser_cts_o(cts),
        .local_fault_lamp_o(lamp_l), .remote_fault_lamp_o(lamp_r),
        .port_a_link_lamp_o(lamp_a), .port_b_link_lamp_o(lamp_b), .alarm_o(alarm));
    // --------------------------------------------------
    // helpers
    // --------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk_sym(input rg_fib_t got, input rg_fib_t exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t symbol %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    // bounded wait for a retimed local space on out_a, one bit plus slack
    task automatic wait_tx;
        int n;
        n = 0;
        while (n < `RG_BIT_DIV + `RG_E2F_CYC && out_a.pri !== 1'b0) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // watchdog, far beyond the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        end_of_test();
    end
    // --------------------------------------------------
    // main sequence
    // --------------------------------------------------
    initial begin
        // chan focal in_a in_b out_a out_b txd, lanes {pri,sec}
        rows = '{'{1'h0, 1'h0, 2'h3, 2'h1, 2'h1, 2'h3, 1'h0},
                 '{1'h0, 1'h0, 2'h3, 2'h2, 2'h2, 2'h3, 1'h1},
                 '{1'h0, 1'h0, 2'h1, 2'h3, 2'h3, 2'h1, 1'h1},
                 '{1'h1, 1'h0, 2'h3, 2'h2, 2'h2, 2'h3, 1'h0},
                 '{1'h0, 1'h1, 2'h3, 2'h1, 2'h3, 2'h3, 1'h0},
                 '{1'h0, 1'h1, 2'h1, 2'h3, 2'h3, 2'h3, 1'h0},
                 '{1'h0, 1'h1, 2'h2, 2'h2, 2'h2, 2'h2, 1'h1},
                 '{1'h1, 1'h1, 2'h3, 2'h2, 2'h3, 2'h3, 1'h0}};
        {rst, ce, up_a, up_b, rxd, rts, pwr} = 7'h7c;
        sym_a = 4'h3;
        sym_b = 4'h3;
        sw    = 7'h70;
        cyc(10);
        chk_sym(out_a, 4'h3);
        chk_bit(txd, 1'b1);
        chk_bit(alarm, 1'b0);
        rst <= 1'b0;
        cyc(8);
        // table of routing cases in normal mode, links up
        foreach (rows[i]) begin
            sw    <= {3'h7, rows[i].chan, rows[i].focal, 2'h0};
            sym_a <= {2'h0, rows[i].fa};
            sym_b <= {2'h0, rows[i].fb};
            cyc(8);
            chk_sym(out_a, {2'h0, rows[i].ea});
            chk_sym(out_b, {2'h0, rows[i].eb});
            chk_bit(txd, rows[i].tx);
        end
        // v-mode switch off: no data routing
        sw    <= 7'h30;
        sym_b <= 4'h1;
        cyc(8);
        chk_sym(out_a, 4'h3);
        chk_bit(txd, 1'b1);
        // fibre to serial and fibre to fibre latency
        sw    <= 7'h70;
        sym_b <= 4'h3;
        cyc(8);
        sym_b <= 4'h1;
        cyc(4);
        chk_bit(txd, 1'b0);
        chk_bit(out_a.pri, 1'b0);
        // local serial data retimed onto out_a in own channel
        // let the incoming space drain first, or the wait ends at once
        sym_b <= 4'h3;
        cyc(4);
        chk_bit(out_a.pri, 1'b1);
        rxd   <= 1'b0;
        wait_tx();
        chk_bit(out_a.pri, 1'b0);
        chk_bit(out_a.sec, 1'b1);
        rxd <= 1'b1;
        cyc(100);
        // focal node loses port b: fault lamps, alarm, dual sending
        sw   <= 7'h74;
        up_b <= 1'b0;
        cyc(6);
        chk_bit(lamp_l, 1'b1);
        chk_bit(lamp_r, 1'b0);
        chk_bit(lamp_b, 1'b0);
        chk_bit(lamp_a, 1'b1);
        chk_bit(alarm, 1'b1);
        chk_bit(out_a.err, 1'b1);
        rxd <= 1'b0;
        wait_tx();
        chk_bit(out_a.pri, 1'b0);
        chk_bit(out_b.pri, 1'b0);
        rxd <= 1'b1;
        cyc(100);
        up_b  <= 1'b1;
        sym_b <= 4'h1;
        cyc(10);
        chk_sym(out_a, 4'h3);
        chk_bit(alarm, 1'b0);
        // remote error status, local-only alarm, power failure
        sw    <= 7'h70;
        sym_a <= 4'hb;
        sym_b <= 4'hb;
        cyc(8);
        chk_bit(lamp_r, 1'b1);
        chk_bit(lamp_l, 1'b0);
        chk_bit(out_a.err, 1'b1);
        chk_bit(out_b.err, 1'b1);
        chk_bit(alarm, 1'b1);
        sw <= 7'h71;
        cyc(6);
        chk_bit(alarm, 1'b0);
        pwr <= 1'b1;
        cyc(6);
        chk_bit(alarm, 1'b1);
        pwr   <= 1'b0;
        sym_a <= 4'h3;
        sym_b <= 4'h3;
        cyc(8);
        chk_bit(lamp_r, 1'b0);
        // handshake transport, barred in dual channel
        sw    <= 7'h62;
        sym_a <= 4'h7;
        rts   <= 1'b1;
        cyc(8);
        chk_bit(cts, 1'b1);
        chk_bit(out_a.rts, 1'b1);
        sym_a <= 4'h3;
        rts   <= 1'b0;
        cyc(8);
        chk_bit(cts, 1'b0);
        sw    <= 7'h72;
        sym_a <= 4'h7;
        cyc(8);
        chk_bit(cts, 1'b0);
        // clock enable low freezes every output while the fibre moves
        ce    <= 1'b0;
        sym_b <= 4'h1;
        cyc(8);
        chk_sym(out_a, 4'h3);
        chk_bit(txd, 1'b1);
        ce <= 1'b1;
        cyc(8);
        chk_sym(out_a, 4'h1);
        chk_bit(txd, 1'b0);
        end_of_test();
    end
endmodule

// File: verilog/rg_cfg.svh
// constants for the dual channel ring repeater
`ifndef RG_CFG_SVH
`define RG_CFG_SVH
// clock rate and timing budgets, times in ns
`define RG_CLK_MHZ 10
`define RG_T_E2F_NS 1000
`define RG_T_F2E_NS 300
`define RG_T_F2F_NS 1060
`define RG_T_DET_NS 3000
`define RG_T_ERR_NS 800
`define RG_E2F_CYC (`RG_T_E2F_NS * `RG_CLK_MHZ / 1000)
`define RG_F2E_CYC (`RG_T_F2E_NS * `RG_CLK_MHZ / 1000)
`define RG_F2F_CYC (`RG_T_F2F_NS * `RG_CLK_MHZ / 1000)
`define RG_DET_CYC (`RG_T_DET_NS * `RG_CLK_MHZ / 1000)
`define RG_ERR_CYC (`RG_T_ERR_NS * `RG_CLK_MHZ / 1000)
// preset bit period in clock cycles and its counter
`define RG_CNT_W 16
`define RG_BIT_DIV 16'h0057
`define RG_CNT_ONE 16'h0001
`define RG_CNT_ZERO 16'h0000
// reset and idle values
`define RG_MARK 1'b1
`define RG_FIB_IDLE 4'h3
`define RG_PIN_RST 20'h00000
`endif

// File: verilog/rg_pkg.sv
// types for the dual channel ring repeater
package rg_pkg;
    // one fibre symbol: error status, handshake, two data lanes
    typedef struct packed {
        logic err;
        logic rts;
        logic pri;
        logic sec;
    } rg_fib_t;
    // configuration switches
    typedef struct packed {
        logic vmode;
        logic ring;
        logic dual;
        logic chan;
        logic focal;
        logic hs;
        logic loc_only;
    } rg_sw_t;
    // every asynchronous input, synchronised together
    typedef struct packed {
        rg_fib_t fa;
        rg_fib_t fb;
        logic    up_a;
        logic    up_b;
        logic    rxd;
        logic    rts;
        logic    pwr_fail;
        rg_sw_t  sw;
    } rg_pin_t;
    typedef enum logic [0:0] {
        RG_NORMAL   = 1'b0,
        RG_FAILOVER = 1'b1
    } rg_mode_t;
endpackage

// File: verilog/rg_ring_repeater.sv
// forwarding logic of a dual channel v-mode ring repeater node
`timescale 1ns/1ns
`include "rg_cfg.svh"
module rg_ring_repeater
    import rg_pkg::*;
(
    input  wire logic    sys_clk_i,
    input  wire logic    rst_i,
    input  wire logic    ce_i,
    input  wire rg_fib_t fibre_in_a_i,
    input  wire rg_fib_t fibre_in_b_i,
    input  wire logic    link_up_a_i,
    input  wire logic    link_up_b_i,
    input  wire logic    ser_rxd_i,
    input  wire logic    ser_rts_i,
    input  wire logic    pwr_fail_i,
    input  wire rg_sw_t  switches_i,
    output rg_fib_t      fibre_out_a_o,
    output rg_fib_t      fibre_out_b_o,
    output logic         ser_txd_o,
    output logic         ser_cts_o,
    output logic         local_fault_lamp_o,
    output logic         remote_fault_lamp_o,
    output logic         port_a_link_lamp_o,
    output logic         port_b_link_lamp_o,
    output logic         alarm_o
);
    localparam int F2E = `RG_F2E_CYC;
    localparam int F2F = `RG_F2F_CYC;
    localparam int DET = `RG_DET_CYC;
    localparam int ERR = `RG_ERR_CYC;

    // ------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------
    rg_pin_t pin_raw;
    rg_pin_t sy1_ff;
    rg_pin_t sy_ff;
    rg_pin_t nxt_sy1;
    rg_pin_t nxt_sy;

    assign pin_raw = '{fa: fibre_in_a_i, fb: fibre_in_b_i,
                       up_a: link_up_a_i, up_b: link_up_b_i,
                       rxd: ser_rxd_i, rts: ser_rts_i,
                       pwr_fail: pwr_fail_i, sw: switches_i};

    // first stage feeds only the second
    always_comb begin
        nxt_sy1 = ce_i ? pin_raw : sy1_ff;
        nxt_sy  = ce_i ? sy1_ff : sy_ff;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sy1_ff <= `RG_PIN_RST;
            sy_ff  <= `RG_PIN_RST;
        end else begin
            sy1_ff <= nxt_sy1;
            sy_ff  <= nxt_sy;
        end
    end

    // ------------------------------------------------------------
    // serial retimer
    // ------------------------------------------------------------
    logic [`RG_CNT_W-1:0] cnt_ff;
    logic [`RG_CNT_W-1:0] nxt_cnt;
    logic                 ret_ff;
    logic                 nxt_ret;

    // free running bit clock; worst delay is one bit period
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_ret = ret_ff;
        if (ce_i) begin
            if (cnt_ff == `RG_BIT_DIV - `RG_CNT_ONE) begin
                nxt_cnt = `RG_CNT_ZERO;
                nxt_ret = sy_ff.rxd;
            end else begin
                nxt_cnt = cnt_ff + `RG_CNT_ONE;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= `RG_CNT_ZERO;
            ret_ff <= `RG_MARK;
        end else begin
            cnt_ff <= nxt_cnt;
            ret_ff <= nxt_ret;
        end
    end

    // ------------------------------------------------------------
    // fault classification and mode
    // ------------------------------------------------------------
    rg_sw_t   sw;
    logic     cfg_ok;
    logic     focal;
    logic     lf;
    logic     rf;
    logic     rts_en;
    rg_fib_t  fa;
    rg_fib_t  fb;
    rg_mode_t mode_ff;
    rg_mode_t nxt_mode;

    assign sw     = sy_ff.sw;
    assign cfg_ok = sw.vmode & sw.ring & sw.dual;
    assign focal  = sw.focal;
    assign lf     = ~sy_ff.up_a | ~sy_ff.up_b;
    // a dead port reads as idle so it injects nothing
    assign fa     = sy_ff.up_a ? sy_ff.fa : rg_fib_t'(`RG_FIB_IDLE);
    assign fb     = sy_ff.up_b ? sy_ff.fb : rg_fib_t'(`RG_FIB_IDLE);
    assign rf     = fa.err | fb.err;
    assign rts_en = sw.hs & ~sw.dual;

    // any known fault puts the node into failover
    always_comb begin
        nxt_mode = mode_ff;
        if (ce_i) begin
            unique case (mode_ff)
                RG_NORMAL: begin
                    if (lf | rf) begin
                        nxt_mode = RG_FAILOVER;
                    end
                end
                RG_FAILOVER: begin
                    if (~lf & ~rf) begin
                        nxt_mode = RG_NORMAL;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_ff <= RG_NORMAL;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // ------------------------------------------------------------
    // routing and outputs
    // ------------------------------------------------------------
    rg_fib_t oa_ff;
    rg_fib_t ob_ff;
    rg_fib_t nxt_oa;
    rg_fib_t nxt_ob;
    logic    txd_ff;
    logic    nxt_txd;
    logic    cts_ff;
    logic    nxt_cts;
    logic    lfl_ff;
    logic    rfl_ff;
    logic    alm_ff;
    logic    lka_ff;
    logic    lkb_ff;
    logic    nxt_alm;

    // lanes are wired-and: mark is idle, any sender may pull low
    always_comb begin
        logic own_b;
        logic own_a;
        logic blk;
        logic lp;
        logic ls;
        logic fo;
        own_b = 1'b1;
        own_a = 1'b1;
        blk   = 1'b0;
        lp    = 1'b1;
        ls    = 1'b1;
        fo    = 1'b0;
        nxt_oa = rg_fib_t'(`RG_FIB_IDLE);
        nxt_ob = rg_fib_t'(`RG_FIB_IDLE);
        nxt_txd = `RG_MARK;
        if (cfg_ok) begin
            fo  = (mode_ff == RG_FAILOVER);
            blk = focal & ~fo;
            lp  = sw.chan ? 1'b1 : ret_ff;
            ls  = sw.chan ? ret_ff : 1'b1;
            // b to a: focal blocks its own channel outside failover
            nxt_oa.pri = lp & (fb.pri | (blk & ~sw.chan));
            nxt_oa.sec = ls & (fb.sec | (blk & sw.chan));
            // a to b: focal keeps its own channel home
            nxt_ob.pri = fa.pri | (focal & ~sw.chan);
            nxt_ob.sec = fa.sec | (focal & sw.chan);
            if (fo) begin
                nxt_ob.pri = nxt_ob.pri & lp;
                nxt_ob.sec = nxt_ob.sec & ls;
            end
            own_b = sw.chan ? fb.sec : fb.pri;
            own_a = sw.chan ? fa.sec : fa.pri;
            nxt_txd = own_b & (own_a | ~focal);
        end
        // error status heads on; focal nodes absorb it
        nxt_oa.err = lf | (~focal & fb.err);
        nxt_ob.err = lf | (~focal & fa.err);
        nxt_oa.rts = rts_en & (sy_ff.rts | (~focal & fb.rts));
        nxt_ob.rts = rts_en & (sy_ff.rts | (~focal & fa.rts));
        nxt_cts = rts_en & (fa.rts | fb.rts);
        nxt_alm = sy_ff.pwr_fail | lf | (rf & ~sw.loc_only);
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            oa_ff  <= `RG_FIB_IDLE;
            ob_ff  <= `RG_FIB_IDLE;
            txd_ff <= `RG_MARK;
            cts_ff <= 1'b0;
            lfl_ff <= 1'b0;
            rfl_ff <= 1'b0;
            alm_ff <= 1'b0;
            lka_ff <= 1'b0;
            lkb_ff <= 1'b0;
        end else if (ce_i) begin
            oa_ff  <= nxt_oa;
            ob_ff  <= nxt_ob;
            txd_ff <= nxt_txd;
            cts_ff <= nxt_cts;
            lfl_ff <= lf;
            rfl_ff <= rf & ~lf;
            alm_ff <= nxt_alm;
            lka_ff <= sy_ff.up_a;
            lkb_ff <= sy_ff.up_b;
        end
    end

    assign fibre_out_a_o       = oa_ff;
    assign fibre_out_b_o       = ob_ff;
    assign ser_txd_o           = txd_ff;
    assign ser_cts_o           = cts_ff;
    assign local_fault_lamp_o  = lfl_ff;
    assign remote_fault_lamp_o = rfl_ff;
    assign port_a_link_lamp_o  = lka_ff;
    assign port_b_link_lamp_o  = lkb_ff;
    assign alarm_o             = alm_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_pri_on_b;
        cfg_ok && sy_ff.up_b && !sw.chan && !sy_ff.fb.pri;
    endsequence

    sequence s_local_space;
        cfg_ok && !sw.chan && !ret_ff;
    endsequence

    local_tx_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        s_local_space and (fb.sec) |=> !fibre_out_a_o.pri && fibre_out_a_o.sec)
        else $error("local data not on port a primary lane");

    deliver_b_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        (cfg_ok && link_up_b_i && !sw.chan && !fibre_in_b_i.pri)
        ##1 (sy_ff.up_b && !sw.chan && cfg_ok)[*2] |=> !ser_txd_o)
        else $error("own channel from port b not delivered in time");

    no_a_deliver_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        cfg_ok && !focal && fb.pri && fb.sec |=> ser_txd_o)
        else $error("non-focal node delivered port a data");

    focal_block_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        s_pri_on_b and (focal && ret_ff && mode_ff == RG_NORMAL)
        |=> fibre_out_a_o.pri)
        else $error("focal node recirculated its own channel");

    foreign_rep_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        cfg_ok && sy_ff.up_b && !sy_ff.fb.sec && !(focal && sw.chan)
        |=> !fibre_out_a_o.sec)
        else $error("foreign channel not repeated to port a");

    both_ports_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        s_local_space and (mode_ff == RG_FAILOVER)
        |=> !fibre_out_a_o.pri && !fibre_out_b_o.pri)
        else $error("failover does not send on both ports");

    fault_det_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        !(link_up_a_i && link_up_b_i) [*3]
        |-> ##[0:DET] (local_fault_lamp_o && fibre_out_b_o.err))
        else $error("segment fault not detected in time");

    err_fwd_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        (!focal && sy_ff.up_a && sy_ff.fa.err) |-> ##[1:ERR] fibre_out_b_o.err)
        else $error("error status not forwarded");

    rts_cts_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        sw.dual |=> !ser_cts_o && !fibre_out_a_o.rts)
        else $error("handshake transport active in dual mode");

    alarm_loc_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        sw.loc_only && !lf && !sy_ff.pwr_fail |=> !alarm_o)
        else $error("alarm raised on remote fault in local-only mode");

    mode_back_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        (mode_ff == RG_FAILOVER && !lf && !rf) |=> mode_ff == RG_NORMAL)
        else $error("failover not left after recovery");

    retime_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        ret_ff != $past(ret_ff) |-> $past(cnt_ff) == `RG_BIT_DIV - `RG_CNT_ONE)
        else $error("serial bit changed off the bit boundary");

    repeat_lat_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        (cfg_ok && !focal && sy_ff.up_a && !sy_ff.fa.pri) |-> ##[1:F2F] !fibre_out_b_o.pri)
        else $error("fibre repeat too slow");

    f2e_lat_a: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
        (cfg_ok && focal && !sw.chan && sy_ff.up_a && sy_ff.up_b
         && !sy_ff.fa.pri) |-> ##[1:F2E] !ser_txd_o)
        else $error("focal port a delivery too slow");
endmodule
